// ===== design/disa_defs.vh
// constants for the dsp interrupt source and acknowledge logic
`ifndef DISA_DEFS_VH
`define DISA_DEFS_VH
`define DISA_ADDR_W 16
`define DISA_DATA_W 24
`define DISA_OFS_MCU_EN 16'hff65
`define DISA_OFS_SRC 16'hff70
`define DISA_OFS_ACK 16'hff71
`define DISA_OFS_TRAP 16'hff72
`define DISA_OFS_CLKSW 16'hff73
`define DISA_MCU_EN_RST 16'h0000
`define DISA_SRC_RST 5'h00
`define DISA_CLKSW_RST 1'b0
`define DISA_ACK_BIT 0
`define DISA_CLKSW_BIT 0
`define DISA_NUM_LOCAL 9
`define DISA_NUM_MCU 16
`define DISA_MCU_CODE_BASE 5'h09
`define DISA_CODE_W 5
`endif

// ===== design/disa_pick.v
// fixed-priority picker of the lowest pending interrupt code
`timescale 1ns/100ps
`include "disa_defs.vh"
module disa_pick #(
	parameter NUM_LOCAL = `DISA_NUM_LOCAL,
	parameter NUM_MCU = `DISA_NUM_MCU
) (
	input wire [NUM_LOCAL-1:0] local_req,
	input wire [NUM_MCU-1:0] mcu_req,
	output reg any,
	output reg [`DISA_CODE_W-1:0] code,
	output reg is_mcu,
	output reg [3:0] mcu_idx
);
	integer i;
	// scan downward so the lowest code wins
	always @* begin
		any = 1'b0;
		code = `DISA_SRC_RST;
		is_mcu = 1'b0;
		mcu_idx = 4'h0;
		for (i = NUM_MCU - 1; i >= 0; i = i - 1) begin
			if (mcu_req[i]) begin
				any = 1'b1;
				is_mcu = 1'b1;
				mcu_idx = i[3:0];
				code = `DISA_MCU_CODE_BASE + i[4:0];
			end
		end
		for (i = NUM_LOCAL - 1; i >= 0; i = i - 1) begin
			if (local_req[i]) begin
				any = 1'b1;
				is_mcu = 1'b0;
				mcu_idx = 4'h0;
				code = i[4:0];
			end
		end
	end
endmodule // disa_pick

// ===== design/disa_top.v
// interrupt source gating, current code and acknowledge handling
`timescale 1ns/100ps
`include "disa_defs.vh"
module disa_top #(
	parameter NUM_MCU = `DISA_NUM_MCU
) (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [`DISA_ADDR_W-1:0] mmio_addr,
	input wire [`DISA_DATA_W-1:0] mmio_wdata,
	input wire mmio_wr,
	input wire mmio_rd,
	input wire [`DISA_NUM_LOCAL-1:0] local_irq,
	input wire [NUM_MCU-1:0] mcu_event,
	output reg [`DISA_DATA_W-1:0] mmio_rdata_ff,
	output reg irq_ff,
	output reg int_clk_sel_ff,
	output reg sw_error_ff,
	output reg [`DISA_CODE_W-1:0] active_code_ff
);
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;

	function hit;
		input [`DISA_ADDR_W-1:0] a;
		input [`DISA_ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	reg state_ff;
	reg nxt_state;
	reg [NUM_MCU-1:0] mcu_en_ff;
	reg [NUM_MCU-1:0] nxt_mcu_en;
	reg clksw_en_ff;
	reg nxt_clksw_en;
	reg served_mcu_ff;
	reg nxt_served_mcu;
	reg [3:0] served_idx_ff;
	reg [3:0] nxt_served_idx;
	reg [`DISA_CODE_W-1:0] nxt_active_code;
	reg nxt_irq;
	reg nxt_int_clk_sel;
	reg nxt_sw_error;
	reg [`DISA_DATA_W-1:0] nxt_rdata;

	wire pick_any;
	wire [`DISA_CODE_W-1:0] pick_code;
	wire pick_is_mcu;
	wire [3:0] pick_idx;
	wire [NUM_MCU-1:0] mcu_live;
	wire wr_ack;
	wire clear_served;
	wire [NUM_MCU-1:0] mcu_pend;
	wire [NUM_MCU-1:0] clr_vec;

	// pending events gated by their enables before arbitration
	assign mcu_live = mcu_pend & mcu_en_ff;
	assign wr_ack = mmio_wr & hit(mmio_addr, `DISA_OFS_ACK);
	assign clear_served = wr_ack & ~mmio_wdata[`DISA_ACK_BIT];
	// only the served source is cleared; bit 0 high leaves it to raise again
	assign clr_vec = (clear_served & served_mcu_ff) ? ({{(NUM_MCU-1){1'b0}}, 1'b1} << served_idx_ff) :
		{NUM_MCU{1'b0}};

	disa_pick #(
		.NUM_LOCAL(`DISA_NUM_LOCAL),
		.NUM_MCU(NUM_MCU)
	) u_pick (
		.local_req(local_irq),
		.mcu_req(mcu_live),
		.any(pick_any),
		.code(pick_code),
		.is_mcu(pick_is_mcu),
		.mcu_idx(pick_idx)
	);

	// one sticky flop per forwarded source; a new event wins over the clear
	genvar g;
	generate
		for (g = 0; g < NUM_MCU; g = g + 1) begin : g_pend
			reg pend_ff;
			always @(posedge clock) begin
				if (rst) begin
					pend_ff <= 1'b0;
				end else if (ce) begin
					if (mcu_event[g]) begin
						pend_ff <= 1'b1;
					end else if (clr_vec[g]) begin
						pend_ff <= 1'b0;
					end
				end
			end
			assign mcu_pend[g] = pend_ff;
		end
	endgenerate

	always @* begin
		nxt_state = state_ff;
		nxt_mcu_en = mcu_en_ff;
		nxt_clksw_en = clksw_en_ff;
		nxt_served_mcu = served_mcu_ff;
		nxt_served_idx = served_idx_ff;
		nxt_active_code = active_code_ff;
		nxt_irq = irq_ff;
		nxt_sw_error = 1'b0;
		nxt_rdata = mmio_rdata_ff;
		if (mmio_wr) begin
			if (hit(mmio_addr, `DISA_OFS_MCU_EN)) begin
				nxt_mcu_en = mmio_wdata[NUM_MCU-1:0];
			end
			if (hit(mmio_addr, `DISA_OFS_CLKSW)) begin
				nxt_clksw_en = mmio_wdata[`DISA_CLKSW_BIT];
			end
		end
		// trap on either access direction, data ignored
		if ((mmio_wr | mmio_rd) && hit(mmio_addr, `DISA_OFS_TRAP)) begin
			nxt_sw_error = 1'b1;
		end
		if (mmio_rd) begin
			nxt_rdata = {`DISA_DATA_W{1'b0}};
			if (hit(mmio_addr, `DISA_OFS_MCU_EN)) begin
				nxt_rdata[NUM_MCU-1:0] = mcu_en_ff;
			end
			if (hit(mmio_addr, `DISA_OFS_SRC)) begin
				nxt_rdata[`DISA_CODE_W-1:0] = active_code_ff;
			end
			if (hit(mmio_addr, `DISA_OFS_CLKSW)) begin
				nxt_rdata[`DISA_CLKSW_BIT] = clksw_en_ff;
			end
		end
		case (state_ff)
			ST_IDLE: begin
				if (pick_any) begin
					nxt_state = ST_BUSY;
					nxt_irq = 1'b1;
					nxt_active_code = pick_code;
					nxt_served_mcu = pick_is_mcu;
					nxt_served_idx = pick_idx;
				end
			end
			ST_BUSY: begin
				// any acknowledge write ends service and re-arms
				if (wr_ack) begin
					nxt_state = ST_IDLE;
					nxt_irq = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_irq = 1'b0;
			end
		endcase
		// rate follows service only when switching is enabled
		nxt_int_clk_sel = (nxt_state == ST_BUSY) & nxt_clksw_en;
	end

	always @(posedge clock) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			mcu_en_ff <= `DISA_MCU_EN_RST;
			clksw_en_ff <= `DISA_CLKSW_RST;
			served_mcu_ff <= 1'b0;
			served_idx_ff <= 4'h0;
			active_code_ff <= `DISA_SRC_RST;
			irq_ff <= 1'b0;
			int_clk_sel_ff <= 1'b0;
			sw_error_ff <= 1'b0;
			mmio_rdata_ff <= {`DISA_DATA_W{1'b0}};
		end else if (ce) begin
			state_ff <= nxt_state;
			mcu_en_ff <= nxt_mcu_en;
			clksw_en_ff <= nxt_clksw_en;
			served_mcu_ff <= nxt_served_mcu;
			served_idx_ff <= nxt_served_idx;
			active_code_ff <= nxt_active_code;
			irq_ff <= nxt_irq;
			int_clk_sel_ff <= nxt_int_clk_sel;
			sw_error_ff <= nxt_sw_error;
			mmio_rdata_ff <= nxt_rdata;
		end
	end
endmodule // disa_top

// ===== verification/disa_chk.sv
// assertion checker for the interrupt source and acknowledge logic
`timescale 1ns/100ps
module disa_chk #(
	parameter NUM_MCU = 16
) (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [15:0] mmio_addr,
	input wire [23:0] mmio_wdata,
	input wire mmio_wr,
	input wire mmio_rd,
	input wire [8:0] local_irq,
	input wire [NUM_MCU-1:0] mcu_event,
	input wire [23:0] mmio_rdata_ff,
	input wire irq_ff,
	input wire int_clk_sel_ff,
	input wire sw_error_ff,
	input wire [4:0] active_code_ff
);
default clocking @(posedge clock); endclocking
// frozen cycles prove nothing, so they are skipped
default disable iff (rst || !ce);
trap_read_a: assert property (mmio_rd && mmio_addr == 16'hff72 |=> sw_error_ff)
	else $error("trap read gave no error");
trap_write_a: assert property (mmio_wr && mmio_addr == 16'hff72 |=> sw_error_ff)
	else $error("trap write gave no error");
err_cause_a: assert property (sw_error_ff |-> $past((mmio_rd || mmio_wr) && mmio_addr == 16'hff72))
	else $error("error without trap access");
ack_drop_a: assert property (mmio_wr && mmio_addr == 16'hff71 |=> !irq_ff && !int_clk_sel_ff)
	else $error("ack left request or rate");
irq_fall_a: assert property ($fell(irq_ff) |-> $past(mmio_wr && mmio_addr == 16'hff71))
	else $error("request dropped without ack");
src_read_a: assert property (mmio_rd && mmio_addr == 16'hff70 |=> mmio_rdata_ff == {19'h0, $past(active_code_ff)})
	else $error("source read wrong");
mask_top_a: assert property (mmio_rd && mmio_addr == 16'hff65 |=> mmio_rdata_ff[23:16] == 8'h0)
	else $error("mask upper bits set");
sel_irq_a: assert property (int_clk_sel_ff |-> irq_ff)
	else $error("fast rate outside service");
cover property ($rose(irq_ff));
cover property (sw_error_ff);
cover property (int_clk_sel_ff);
cover property (irq_ff && mmio_wr && mmio_addr == 16'hff71 && mmio_wdata[0]);
endmodule // disa_chk
bind disa_top disa_chk #(.NUM_MCU(NUM_MCU)) disa_chk_i(.clock, .rst, .ce, .mmio_addr,
	.mmio_wdata, .mmio_wr, .mmio_rd, .local_irq, .mcu_event, .mmio_rdata_ff, .irq_ff,
	.int_clk_sel_ff, .sw_error_ff, .active_code_ff);

// ===== verification/disa_mcu_model.sv
// companion processor model: each raised request becomes one event cycle
`timescale 1ns/100ps
module disa_mcu_model (
	input wire clock,
	input wire [15:0] req,
	output logic [15:0] mcu_event
);
logic [15:0] req_q = 0;
initial mcu_event = 0;
always @(posedge clock) begin
	mcu_event <= req & ~req_q;
	req_q <= req;
end
endmodule // disa_mcu_model

// ===== verification/disa_top_tb.sv
// testbench for the interrupt source and acknowledge logic
`timescale 1ns/100ps
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module disa_top_tb;
logic clock = 0, rst = 1, wr = 0, rd = 0, ce = 1;
logic [15:0] addr = 0, fire = 0, ev;
logic [23:0] wd = 0, rdata;
logic [8:0] li = 0;
logic irq, csel, swe;
logic [4:0] code;
int err_total = 0, num_checks = 0;
always #12.5 clock = ~clock;
disa_mcu_model disa_mcu_model_i(.clock, .req(fire), .mcu_event(ev));
disa_top disa_top_i(.clock, .rst, .ce(ce), .mmio_addr(addr), .mmio_wdata(wd), .mmio_wr(wr),
	.mmio_rd(rd), .local_irq(li), .mcu_event(ev), .mmio_rdata_ff(rdata), .irq_ff(irq),
	.int_clk_sel_ff(csel), .sw_error_ff(swe), .active_code_ff(code));
task results;
	$display("checks %0d errors %0d", num_checks, err_total);
	if (err_total == 0 && num_checks > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
// one strobe cycle; read data and error pulse are settled on return
task automatic acc(input logic w, input logic [15:0] a, input logic [23:0] d);
	@(negedge clock);
	wr = w;
	rd = !w;
	addr = a;
	wd = d;
	@(negedge clock);
	wr = 0;
	rd = 0;
endtask
task automatic wirq;
	for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clock);
	if (irq !== 1'b1) begin
		err_total++;
		results();
	end
endtask
initial begin
	repeat (5) @(negedge clock);
	rst = 0;
	acc(0, 16'hff65, 0);
	`CHK("mask", 24'h0, rdata)
	acc(1, 16'hff72, 0);
	`CHK("err", 1'b1, swe)
	acc(0, 16'hff72, 0);
	`CHK("err", 1'b1, swe)
	fire = 1;
	repeat (4) @(negedge clock);
	`CHK("irq", 1'b0, irq)
	acc(1, 16'hff65, 24'hffffff);
	acc(0, 16'hff65, 0);
	`CHK("mask", 24'h00ffff, rdata)
	wirq();
	acc(0, 16'hff70, 0);
	`CHK("src", 24'h000009, rdata)
	for (int n = 11; n < 16; n++) begin
		// upper ack bits set to show they are ignored
		acc(1, 16'hff71, 24'hfffffe);
		repeat (3) @(negedge clock);
		`CHK("irq", 1'b0, irq)
		fire = 16'(1 << n);
		wirq();
		`CHK("code", 5'(9 + n), code)
		`CHK("csel", 1'b0, csel)
	end
	acc(1, 16'hff71, 0);
	`CHK("irq", 1'b0, irq)
	acc(1, 16'hff73, 1);
	for (int k = 0; k < 9; k++) begin
		li = 9'(1 << k);
		wirq();
		`CHK("code", 5'(k), code)
		`CHK("csel", 1'b1, csel)
		li = 0;
		acc(1, 16'hff71, 0);
		`CHK("csel", 1'b0, csel)
	end
	// bit 0 high acknowledges but keeps the event pending, so it comes back
	fire = 16'h0001;
	wirq();
	acc(1, 16'hff71, 24'h000001);
	`CHK("irq", 1'b0, irq)
	wirq();
	`CHK("code", 5'h09, code)
	acc(1, 16'hff71, 0);
	repeat (3) @(negedge clock);
	`CHK("irq", 1'b0, irq)
	// lowest code wins when sources meet
	li = 9'h180;
	fire = 16'h0002;
	wirq();
	`CHK("code", 5'h07, code)
	li = 9'h100;
	acc(1, 16'hff71, 0);
	wirq();
	`CHK("code", 5'h08, code)
	li = 0;
	acc(1, 16'hff71, 0);
	wirq();
	`CHK("code", 5'h0a, code)
	acc(1, 16'hff71, 0);
	// frozen cycles take neither a request nor an access
	ce = 0;
	li = 9'h001;
	acc(0, 16'hff72, 0);
	`CHK("err", 1'b0, swe)
	`CHK("irq", 1'b0, irq)
	`CHK("code", 5'h0a, code)
	ce = 1;
	wirq();
	`CHK("code", 5'h00, code)
	// reset in mid-service drops everything back to idle
	rst = 1;
	li = 0;
	repeat (2) @(negedge clock);
	`CHK("irq", 1'b0, irq)
	`CHK("csel", 1'b0, csel)
	rst = 0;
	acc(0, 16'hff65, 0);
	`CHK("mask", 24'h0, rdata)
	acc(0, 16'hff70, 0);
	`CHK("src", 24'h0, rdata)
	results();
end
endmodule // disa_top_tb
